// >>> pkg/cvrl_pkg.sv
// Purpose: shared constants and types for the current/voltage result and limit block
// Assumes: 8-bit register map reached over a two-wire serial management port
// Notes: status register offsets sit beside the documented map
package cvrl_pkg;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_HIGH_STATUS = 8'h35;
    localparam logic [7:0] ADDR_LOW_STATUS = 8'h36;
    localparam logic [7:0] ADDR_BUS_VOLT_CFG = 8'h50;
    localparam logic [7:0] ADDR_SENSE_CFG = 8'h51;
    localparam logic [7:0] ADDR_SPIKE_CFG = 8'h52;
    localparam logic [7:0] ADDR_SENSE_RESULT_HIGH = 8'h54;
    localparam logic [7:0] ADDR_SENSE_RESULT_LOW = 8'h55;
    localparam logic [7:0] ADDR_BUS_VOLT_RESULT_HIGH = 8'h58;
    localparam logic [7:0] ADDR_BUS_VOLT_RESULT_LOW = 8'h59;
    localparam logic [7:0] ADDR_POWER_FACTOR_HIGH = 8'h5b;
    localparam logic [7:0] ADDR_POWER_FACTOR_LOW = 8'h5c;
    localparam logic [7:0] ADDR_SENSE_UPPER_BOUND = 8'h60;
    localparam logic [7:0] ADDR_SENSE_LOWER_BOUND = 8'h61;
    localparam logic [7:0] ADDR_BUS_VOLT_UPPER_BOUND = 8'h64;
    localparam logic [7:0] ADDR_BUS_VOLT_LOWER_BOUND = 8'h65;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_RESULT = 8'h00;
    localparam logic [7:0] RST_BUS_VOLT_CFG = 8'h00;
    localparam logic [7:0] RST_SENSE_CFG = 8'h03;
    localparam logic [7:0] RST_SPIKE_CFG = 8'h00;
    localparam logic [7:0] RST_SENSE_UPPER_BOUND = 8'h7f;
    localparam logic [7:0] RST_SENSE_LOWER_BOUND = 8'h80;
    localparam logic [7:0] RST_BUS_VOLT_UPPER_BOUND = 8'hff;
    localparam logic [7:0] RST_BUS_VOLT_LOWER_BOUND = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int SENSE_QUEUE_LSB = 6;
    localparam int BUS_VOLT_QUEUE_LSB = 2;
    localparam int SPIKE_LEVEL_LSB = 4;
    localparam int SPIKE_MIN_TIME_LSB = 0;
    localparam int FULL_SCALE_LSB = 0;
    localparam int SENSE_W = 12;
    localparam int BUS_VOLT_W = 11;
    localparam int POWER_W = 16;
    localparam int POWER_LSB = 7;
    localparam int BUS_VOLT_LOW_PAD = 5;
    localparam int SENSE_LOW_PAD = 4;
    localparam logic [2:0] QUEUE_MAX = 3'h4;

    // ----------------------------------------------------------------
    // decode tables
    // ----------------------------------------------------------------
    localparam logic [21:0] SPIKE_TIME_US [16] = '{
        22'h0003e8, 22'h001400, 22'h006400, 22'h00c800,
        22'h012c00, 22'h019000, 22'h01f400, 22'h03e800,
        22'h05dc00, 22'h07d000, 22'h0bb800, 22'h0fa000,
        22'h177000, 22'h1f4000, 22'h2ee000, 22'h3e8000};
    localparam logic [6:0] FULL_SCALE_MV [4] = '{7'h0a, 7'h14, 7'h28, 7'h50};

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic busVolt;
        logic sense;
    } cvrl_pair_t;

    typedef struct packed {
        logic valid;
        logic signed [SENSE_W-1:0] value;
    } cvrl_sample_t;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_ADDR = 7'h02,
        ST_ADDR_ACK = 7'h04,
        ST_WRITE = 7'h08,
        ST_WRITE_ACK = 7'h10,
        ST_READ = 7'h20,
        ST_READ_ACK = 7'h40
    } cvrl_state_t;

endpackage

// >>> core/cvrl_core.sv
// Purpose: result registers, limit checks and serial register port of the monitor
// Assumes: front end delivers samples on ref_clk; serial pins are asynchronous
// Notes: status flags clear when read; the alert pin follows any raised flag
`timescale 1ns/10ps

// ----------------------------------------------------------------
// consecutive out-of-limit counter
// ----------------------------------------------------------------
module cvrl_queue (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic update,
    input wire logic outOfLimit,
    input wire logic [1:0] depth,
    output logic hit
);
    import cvrl_pkg::*;
    logic [2:0] count;

    // the count saturates so a long excursion keeps hitting on every update
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            count <= 3'h0;
        end else if (update) begin
            if (!outOfLimit) begin
                count <= 3'h0;
            end else if (count != QUEUE_MAX) begin
                count <= count + 3'h1;
            end
        end
    end

    assign hit = update && outOfLimit && (count >= {1'b0, depth});
endmodule

// Operation
// - spike time field decodes to 1ms up through 4096ms in sixteen steps
// - sense result is 12 bits, read only, split over 54h and 55h upper nibble
// - sense result is two's complement, 7FFh and 800h are full scale
// - sign bit zero for current from positive to negative sense pin
// - stored sense code is the raw two's complement sample, no internal scaling applied
// - source result split over 58h and 59h, five low bits read zero
// - source code is unsigned binary, top bit weighs 12 volts
// - negative source readings are stored as zero
// - power ratio is sense magnitude times source cut to 16 bits at 5Bh/5Ch
// - each sense update compares against limits at 60h and 61h
// - sense at or above high, or below low, raises alert and flag
// - sense limit comparison is signed
// - sense limits are raw codes relative to programmed full scale
// - each source update compares against limits at 64h and 65h
// - source at or above high, or below low, raises alert and flag
// - a violation flags only after one to four consecutive bad samples
// - two-bit range field selects 10, 20, 40 or 80 mV, default 80
module cvrl_core #(
    parameter logic [6:0] DEV_ADDR = 7'h2a
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire cvrl_pkg::cvrl_sample_t senseSample,
    input wire cvrl_pkg::cvrl_sample_t busVoltSample,
    output logic alertN,
    output cvrl_pkg::cvrl_pair_t overFlags,
    output cvrl_pkg::cvrl_pair_t underFlags,
    output logic [21:0] spikeMinTimeUs,
    output logic [3:0] spikeLevel,
    output logic [6:0] senseFullScaleMv
);
    import cvrl_pkg::*;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic sclMeta, sclSync, sclPrev, sdaMeta, sdaSync, sdaPrev;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            {sclMeta, sclSync, sclPrev} <= 3'h7;
            {sdaMeta, sdaSync, sdaPrev} <= 3'h7;
        end else begin
            {sclMeta, sclSync, sclPrev} <= {sclIn, sclMeta, sclSync};
            {sdaMeta, sdaSync, sdaPrev} <= {sdaIn, sdaMeta, sdaSync};
        end
    end

    logic sclRise, sclFall, busStart, busStop;
    assign sclRise = sclSync && !sclPrev;
    assign sclFall = !sclSync && sclPrev;
    assign busStart = sclSync && sclPrev && sdaPrev && !sdaSync;
    assign busStop = sclSync && sclPrev && !sdaPrev && sdaSync;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic signed [SENSE_W-1:0] senseResult;
    logic [BUS_VOLT_W-1:0] busVoltResult;
    logic [POWER_W-1:0] powerFactor;
    logic [7:0] senseUpperBound, senseLowerBound;
    logic [7:0] busVoltUpperBound, busVoltLowerBound;
    logic [7:0] busVoltCfg, senseCfg, spikeCfg;
    logic wrStb, rdStb;
    logic [7:0] wrAddr, wrData, rdAddr;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            senseUpperBound <= RST_SENSE_UPPER_BOUND;
            senseLowerBound <= RST_SENSE_LOWER_BOUND;
            busVoltUpperBound <= RST_BUS_VOLT_UPPER_BOUND;
            busVoltLowerBound <= RST_BUS_VOLT_LOWER_BOUND;
            busVoltCfg <= RST_BUS_VOLT_CFG;
            senseCfg <= RST_SENSE_CFG;
            spikeCfg <= RST_SPIKE_CFG;
        end else if (wrStb) begin
            case (wrAddr)
                ADDR_SENSE_UPPER_BOUND: senseUpperBound <= wrData;
                ADDR_SENSE_LOWER_BOUND: senseLowerBound <= wrData;
                ADDR_BUS_VOLT_UPPER_BOUND: busVoltUpperBound <= wrData;
                ADDR_BUS_VOLT_LOWER_BOUND: busVoltLowerBound <= wrData;
                ADDR_BUS_VOLT_CFG: busVoltCfg <= wrData;
                ADDR_SENSE_CFG: senseCfg <= wrData;
                ADDR_SPIKE_CFG: spikeCfg <= wrData;
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // results and power
    // ----------------------------------------------------------------
    logic [SENSE_W-1:0] senseMag;
    logic [SENSE_W+BUS_VOLT_W-1:0] powerProduct;
    assign senseMag = senseResult[SENSE_W-1] ? SENSE_W'(-senseResult) : senseResult;
    assign powerProduct = senseMag * busVoltResult;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            senseResult <= '0;
            busVoltResult <= '0;
            powerFactor <= '0;
        end else begin
            if (senseSample.valid) begin
                senseResult <= senseSample.value;
            end
            if (busVoltSample.valid) begin
                busVoltResult <= busVoltSample.value[SENSE_W-1] ? '0 :
                    busVoltSample.value[BUS_VOLT_W-1:0];
            end
            powerFactor <= powerProduct[POWER_LSB +: POWER_W];
        end
    end

    // ----------------------------------------------------------------
    // limit checks
    // ----------------------------------------------------------------
    logic signed [7:0] senseTop;
    logic [7:0] busVoltTop;
    logic senseHi, senseLo, busVoltHi, busVoltLo;
    cvrl_pair_t overHit, underHit, statusClrHigh, statusClrLow;

    assign senseTop = senseSample.value[SENSE_W-1 -: 8];
    assign busVoltTop = busVoltSample.value[SENSE_W-1] ? 8'h00 :
        busVoltSample.value[BUS_VOLT_W-1 -: 8];
    assign senseHi = senseTop >= $signed(senseUpperBound);
    assign senseLo = senseTop < $signed(senseLowerBound);
    assign busVoltHi = busVoltTop >= busVoltUpperBound;
    assign busVoltLo = busVoltTop < busVoltLowerBound;

    cvrl_queue senseHiQueue (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .update(senseSample.valid), .outOfLimit(senseHi),
        .depth(senseCfg[SENSE_QUEUE_LSB +: 2]), .hit(overHit.sense));
    cvrl_queue senseLoQueue (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .update(senseSample.valid), .outOfLimit(senseLo),
        .depth(senseCfg[SENSE_QUEUE_LSB +: 2]), .hit(underHit.sense));
    cvrl_queue busVoltHiQueue (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .update(busVoltSample.valid), .outOfLimit(busVoltHi),
        .depth(busVoltCfg[BUS_VOLT_QUEUE_LSB +: 2]), .hit(overHit.busVolt));
    cvrl_queue busVoltLoQueue (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .update(busVoltSample.valid), .outOfLimit(busVoltLo),
        .depth(busVoltCfg[BUS_VOLT_QUEUE_LSB +: 2]), .hit(underHit.busVolt));

    assign statusClrHigh = (rdStb && rdAddr == ADDR_HIGH_STATUS) ? 2'h3 : 2'h0;
    assign statusClrLow = (rdStb && rdAddr == ADDR_LOW_STATUS) ? 2'h3 : 2'h0;

    // a new violation in the clearing cycle survives the clear
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            overFlags <= '0;
            underFlags <= '0;
            alertN <= 1'b1;
        end else begin
            overFlags <= (overFlags & ~statusClrHigh) | overHit;
            underFlags <= (underFlags & ~statusClrLow) | underHit;
            alertN <= !((|overHit) || (|underHit) ||
                (|(overFlags & ~statusClrHigh)) || (|(underFlags & ~statusClrLow)));
        end
    end

    // ----------------------------------------------------------------
    // decoded settings
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            spikeMinTimeUs <= SPIKE_TIME_US[RST_SPIKE_CFG[SPIKE_MIN_TIME_LSB +: 4]];
            spikeLevel <= RST_SPIKE_CFG[SPIKE_LEVEL_LSB +: 4];
            senseFullScaleMv <= FULL_SCALE_MV[RST_SENSE_CFG[FULL_SCALE_LSB +: 2]];
        end else begin
            spikeMinTimeUs <= SPIKE_TIME_US[spikeCfg[SPIKE_MIN_TIME_LSB +: 4]];
            spikeLevel <= spikeCfg[SPIKE_LEVEL_LSB +: 4];
            senseFullScaleMv <= FULL_SCALE_MV[senseCfg[FULL_SCALE_LSB +: 2]];
        end
    end

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    logic [7:0] readByte;
    always_comb begin
        case (rdAddr)
            ADDR_HIGH_STATUS: readByte = {6'h00, overFlags};
            ADDR_LOW_STATUS: readByte = {6'h00, underFlags};
            ADDR_BUS_VOLT_CFG: readByte = busVoltCfg;
            ADDR_SENSE_CFG: readByte = senseCfg;
            ADDR_SPIKE_CFG: readByte = spikeCfg;
            ADDR_SENSE_RESULT_HIGH: readByte = senseResult[SENSE_W-1 -: 8];
            ADDR_SENSE_RESULT_LOW: readByte = {senseResult[3:0], 4'h0};
            ADDR_BUS_VOLT_RESULT_HIGH: readByte = busVoltResult[BUS_VOLT_W-1 -: 8];
            ADDR_BUS_VOLT_RESULT_LOW: readByte = {busVoltResult[2:0], 5'h00};
            ADDR_POWER_FACTOR_HIGH: readByte = powerFactor[15:8];
            ADDR_POWER_FACTOR_LOW: readByte = powerFactor[7:0];
            ADDR_SENSE_UPPER_BOUND: readByte = senseUpperBound;
            ADDR_SENSE_LOWER_BOUND: readByte = senseLowerBound;
            ADDR_BUS_VOLT_UPPER_BOUND: readByte = busVoltUpperBound;
            ADDR_BUS_VOLT_LOWER_BOUND: readByte = busVoltLowerBound;
            default: readByte = READ_UNMAPPED;
        endcase
    end

    // ----------------------------------------------------------------
    // serial register port
    // ----------------------------------------------------------------
    cvrl_state_t state;
    logic [7:0] shiftByte, txByte, regPtr;
    logic [3:0] bitCnt;
    logic readMode, pointerPhase, masterNack;

    // drive is asserted only after scl falls; a start or stop releases it while scl is high
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state <= ST_IDLE;
            shiftByte <= 8'h00;
            txByte <= 8'h00;
            regPtr <= 8'h00;
            bitCnt <= 4'h0;
            readMode <= 1'b0;
            pointerPhase <= 1'b0;
            masterNack <= 1'b0;
            sdaOe <= 1'b0;
            sdaOut <= 1'b0;
            wrStb <= 1'b0;
            wrAddr <= 8'h00;
            wrData <= 8'h00;
            rdStb <= 1'b0;
            rdAddr <= 8'h00;
        end else begin
            wrStb <= 1'b0;
            rdStb <= 1'b0;
            sdaOut <= 1'b0;
            if (busStart) begin
                state <= ST_ADDR;
                bitCnt <= 4'h0;
                sdaOe <= 1'b0;
            end else if (busStop) begin
                state <= ST_IDLE;
                sdaOe <= 1'b0;
            end else if (sclRise) begin
                if (state == ST_ADDR || state == ST_WRITE) begin
                    shiftByte <= {shiftByte[6:0], sdaSync};
                    bitCnt <= bitCnt + 4'h1;
                end else if (state == ST_READ_ACK) begin
                    masterNack <= sdaSync;
                end
            end else if (sclFall) begin
                case (state)
                    ST_ADDR: if (bitCnt == 4'h8) begin
                        if (shiftByte[7:1] == DEV_ADDR) begin
                            state <= ST_ADDR_ACK;
                            readMode <= shiftByte[0];
                            sdaOe <= 1'b1;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                    ST_ADDR_ACK: begin
                        bitCnt <= 4'h0;
                        pointerPhase <= 1'b1;
                        if (readMode) begin
                            state <= ST_READ;
                            txByte <= readByte;
                            rdStb <= 1'b1;
                            sdaOe <= !readByte[7];
                            bitCnt <= 4'h1;
                        end else begin
                            state <= ST_WRITE;
                            sdaOe <= 1'b0;
                        end
                    end
                    ST_WRITE: if (bitCnt == 4'h8) begin
                        state <= ST_WRITE_ACK;
                        sdaOe <= 1'b1;
                        if (pointerPhase) begin
                            regPtr <= shiftByte;
                            rdAddr <= shiftByte;
                        end else begin
                            wrStb <= 1'b1;
                            wrAddr <= regPtr;
                            wrData <= shiftByte;
                            regPtr <= regPtr + 8'h01;
                            rdAddr <= regPtr + 8'h01;
                        end
                    end
                    ST_WRITE_ACK: begin
                        state <= ST_WRITE;
                        sdaOe <= 1'b0;
                        bitCnt <= 4'h0;
                        pointerPhase <= 1'b0;
                    end
                    ST_READ: if (bitCnt == 4'h8) begin
                        state <= ST_READ_ACK;
                        sdaOe <= 1'b0;
                        regPtr <= regPtr + 8'h01;
                        rdAddr <= regPtr + 8'h01;
                    end else begin
                        sdaOe <= !txByte[3'(4'h7 - bitCnt)];
                        bitCnt <= bitCnt + 4'h1;
                    end
                    ST_READ_ACK: if (masterNack) begin
                        state <= ST_IDLE;
                    end else begin
                        state <= ST_READ;
                        txByte <= readByte;
                        rdStb <= 1'b1;
                        sdaOe <= !readByte[7];
                        bitCnt <= 4'h1;
                    end
                    default: ;
                endcase
            end
        end
    end
endmodule

// >>> verif/cvrl_core_sva.sv
// Purpose: port assertions for cvrl_core
// Assumes: sample valid is a one-cycle pulse; one clock domain
// Notes: limits live inside, so flag causes are checked rather than thresholds
`timescale 1ns/10ps
module cvrl_core_sva (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic sclIn,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire cvrl_pkg::cvrl_sample_t senseSample,
    input wire cvrl_pkg::cvrl_sample_t busVoltSample,
    input wire logic alertN,
    input wire cvrl_pkg::cvrl_pair_t overFlags,
    input wire cvrl_pkg::cvrl_pair_t underFlags,
    input wire logic [21:0] spikeMinTimeUs,
    input wire logic [3:0] spikeLevel,
    input wire logic [6:0] senseFullScaleMv
);
    import cvrl_pkg::*;
    // ----------
    // checks
    // ----------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    sequence s_took_sample;
        $past(senseSample.valid || busVoltSample.valid);
    endsequence
    a_sense_over: assert property ($rose(overFlags.sense) |-> $past(senseSample.valid))
        else $error("sense over flag rose without a sample");
    a_sense_under: assert property ($rose(underFlags.sense) |-> $past(senseSample.valid))
        else $error("sense under flag rose without a sample");
    a_bus_over: assert property ($rose(overFlags.busVolt) |-> $past(busVoltSample.valid))
        else $error("voltage over flag rose without a sample");
    a_bus_under: assert property ($rose(underFlags.busVolt) |-> $past(busVoltSample.valid))
        else $error("voltage under flag rose without a sample");
    a_alert_held: assert property ((|overFlags || |underFlags) |-> !alertN)
        else $error("alert released while a flag is set");
    a_alert_cause: assert property ($fell(alertN) |-> s_took_sample)
        else $error("alert fell without a sample");
    a_reset_state: assert property ($fell(sys_rst) |-> alertN && overFlags == 2'h0 &&
        underFlags == 2'h0 && spikeMinTimeUs == 22'h3e8 && senseFullScaleMv == 7'h50)
        else $error("outputs not at reset values");
    a_range_legal: assert property (senseFullScaleMv inside {7'h0a, 7'h14, 7'h28, 7'h50})
        else $error("full scale outside the four ranges");
    a_spike_write: assert property ($changed({spikeMinTimeUs, spikeLevel}) |-> !sclIn)
        else $error("spike fields changed outside a serial write");
    a_drive_low: assert property ($rose(sdaOe) |-> !sclIn && sdaOut == 1'b0)
        else $error("data line driven while clock high or not low");
endmodule
bind cvrl_core cvrl_core_sva u_sva (.ref_clk(ref_clk), .sys_rst(sys_rst), .sclIn(sclIn),
    .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .senseSample(senseSample),
    .busVoltSample(busVoltSample), .alertN(alertN), .overFlags(overFlags),
    .underFlags(underFlags), .spikeMinTimeUs(spikeMinTimeUs), .spikeLevel(spikeLevel),
    .senseFullScaleMv(senseFullScaleMv));

// >>> verif/cvrl_host.sv
// Purpose: serial management host model for the register port
// Assumes: data line has a pull-up, so a one is sent by releasing it
// Notes: data moves a half phase after the clock falls to keep hold margin
`timescale 1ns/10ps
module cvrl_host #(
    parameter logic [6:0] DEV = 7'h2a,
    parameter int HALF = 8
) (
    input wire logic ref_clk,
    input wire logic sdaLine,
    output logic scl,
    output logic sdaOe,
    output logic rdDone,
    output logic [7:0] rdData
);
    logic [8:0] rx;
    initial begin
        scl = 1'b1;
        sdaOe = 1'b0;
        rdDone = 1'b0;
        rdData = 8'h00;
    end
    task automatic tick();
        repeat (HALF) @(posedge ref_clk);
        #1;
    endtask
    task automatic xfer(input logic [8:0] d);
        for (int i = 8; i >= 0; i--) begin
            tick();
            sdaOe = !d[i];
            tick();
            scl = 1'b1;
            tick();
            rx[i] = sdaLine;
            scl = 1'b0;
        end
    endtask
    task automatic cond(input logic stop);
        tick();
        sdaOe = stop;
        tick();
        scl = 1'b1;
        tick();
        sdaOe = !stop;
        tick();
        scl = stop;
    endtask
    // the register fields may be rewritten at any time
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cond(1'b0);
        xfer({DEV, 2'b01});
        xfer({a, 1'b1});
        xfer({d, 1'b1});
        cond(1'b1);
    endtask
    task automatic rd(input logic [7:0] a);
        cond(1'b0);
        xfer({DEV, 2'b01});
        xfer({a, 1'b1});
        cond(1'b0);
        xfer({DEV, 2'b11});
        xfer(9'h1ff);
        cond(1'b1);
        rdData = rx[8:1];
        rdDone = 1'b1;
        @(posedge ref_clk);
        #1;
        rdDone = 1'b0;
    endtask
endmodule

// >>> verif/test_cvrl_core.sv
// Purpose: self-checking bench for cvrl_core
// Assumes: 200 MHz ref_clk; the host model owns the serial pins
// Notes: register reads are checked through a queue of expected bytes
`timescale 1ns/10ps
`define CMP(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_cvrl_core;
    import cvrl_pkg::*;
    logic ref_clk, sys_rst, sdaOut, sdaOe, hostOe, scl, rdDone, alertN;
    cvrl_sample_t senseSample, busVoltSample;
    cvrl_pair_t overFlags, underFlags;
    logic [21:0] spikeMinTimeUs;
    logic [3:0] spikeLevel;
    logic [6:0] senseFullScaleMv;
    logic [7:0] rdData, expByte;
    logic [7:0] expQ[$];
    int num_errors = 0, cmp_count = 0, cyc = 0, seed = 25;
    logic [15:0] rstTab [12] = '{16'h5400, 16'h5500, 16'h5800, 16'h5900, 16'h5b00, 16'h5c00,
        16'h607f, 16'h6180, 16'h64ff, 16'h6500, 16'h5103, 16'h7000};
    logic [6:0] fsTab [4] = '{7'h0a, 7'h14, 7'h28, 7'h50};
    logic [21:0] usTab [16] = '{22'h3e8, 22'h1400, 22'h6400, 22'hc800, 22'h12c00, 22'h19000,
        22'h1f400, 22'h3e800, 22'h5dc00, 22'h7d000, 22'hbb800, 22'hfa000, 22'h177000,
        22'h1f4000, 22'h2ee000, 22'h3e8000};
    wire sdaLine = !(hostOe || sdaOe);
    cvrl_core uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .sclIn(scl), .sdaIn(sdaLine),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .senseSample(senseSample), .busVoltSample(busVoltSample),
        .alertN(alertN), .overFlags(overFlags), .underFlags(underFlags),
        .spikeMinTimeUs(spikeMinTimeUs), .spikeLevel(spikeLevel),
        .senseFullScaleMv(senseFullScaleMv));
    cvrl_host #(.DEV(7'h2a), .HALF(8)) host (.ref_clk(ref_clk), .sdaLine(sdaLine), .scl(scl),
        .sdaOe(hostOe), .rdDone(rdDone), .rdData(rdData));
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = !ref_clk;
    end
    task automatic close_out();
        if (expQ.size() != 0) num_errors++;
        $display("compares %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic rdq(input logic [7:0] a, input logic [7:0] e);
        expQ.push_back(e);
        host.rd(a);
    endtask
    // one-cycle valid pulse; the other channel sees an idle sample
    task automatic put(input logic bv, input logic [11:0] v);
        @(posedge ref_clk);
        #1;
        {busVoltSample, senseSample} = bv ? {1'b1, v, 13'h0000} : {13'h0000, 1'b1, v};
        @(posedge ref_clk);
        #1;
        {busVoltSample.valid, senseSample.valid} = 2'b00;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (rdDone) begin
            expByte = expQ.pop_front();
            `CMP(rdData, expByte)
        end
        if (cyc == 90000) begin
            num_errors++;
            close_out();
        end
    end
    initial begin
        logic [3:0] lvl;
        logic [11:0] s, v, mag;
        logic [10:0] bv;
        logic [22:0] p;
        sys_rst = 1'b1;
        {senseSample, busVoltSample} = 26'h0000000;
        repeat (8) @(posedge ref_clk);
        #1;
        sys_rst = 1'b0;
        repeat (4) @(posedge ref_clk);
        foreach (rstTab[i]) rdq(rstTab[i][15:8], rstTab[i][7:0]);
        host.wr(8'h54, 8'haa);
        rdq(8'h54, 8'h00);
        put(1'b0, 12'h7f3);
        `CMP(overFlags.sense, 1'b1)
        `CMP(alertN, 1'b0)
        rdq(8'h54, 8'h7f);
        rdq(8'h55, 8'h30);
        rdq(8'h35, 8'h01);
        host.wr(8'h61, 8'hf0);
        rdq(8'h61, 8'hf0);
        put(1'b0, 12'h7e0);
        `CMP(overFlags.sense, 1'b0)
        put(1'b0, 12'h100);
        `CMP(underFlags.sense, 1'b0)
        put(1'b0, 12'hf00);
        `CMP(underFlags.sense, 1'b0)
        put(1'b0, 12'hef0);
        `CMP(underFlags.sense, 1'b1)
        put(1'b0, 12'h800);
        `CMP(overFlags.sense, 1'b0)
        put(1'b1, 12'h7ff);
        `CMP(overFlags.busVolt, 1'b1)
        rdq(8'h58, 8'hff);
        rdq(8'h59, 8'he0);
        host.wr(8'h65, 8'h10);
        put(1'b1, 12'h080);
        `CMP(underFlags.busVolt, 1'b0)
        put(1'b1, 12'hc00);
        `CMP(underFlags.busVolt, 1'b1)
        rdq(8'h58, 8'h00);
        rdq(8'h35, 8'h02);
        rdq(8'h36, 8'h03);
        host.wr(8'h51, 8'h43);
        put(1'b0, 12'h7f0);
        put(1'b0, 12'h000);
        put(1'b0, 12'h7f0);
        `CMP(overFlags.sense, 1'b0)
        put(1'b0, 12'h7f0);
        `CMP(overFlags.sense, 1'b1)
        for (int i = 0; i < 4; i++) begin
            host.wr(8'h51, 8'(i));
            `CMP(senseFullScaleMv, fsTab[i])
        end
        for (int i = 0; i < 16; i++) begin
            lvl = 4'($random(seed));
            host.wr(8'h52, {lvl, 4'(i)});
            `CMP(spikeMinTimeUs, usTab[i])
            `CMP(spikeLevel, lvl)
        end
        for (int i = 0; i < 3; i++) begin
            s = 12'($random(seed));
            v = 12'($random(seed));
            put(1'b0, s);
            put(1'b1, v);
            bv = v[11] ? 11'h000 : v[10:0];
            mag = s[11] ? 12'(-s) : s;
            p = mag * bv;
            rdq(8'h54, s[11:4]);
            rdq(8'h55, {s[3:0], 4'h0});
            rdq(8'h58, bv[10:3]);
            rdq(8'h59, {bv[2:0], 5'h00});
            rdq(8'h5b, p[22:15]);
            rdq(8'h5c, p[14:7]);
        end
        close_out();
    end
endmodule
